// ### bench/marx_checker.sv
`timescale 1ns/100ps
// ==========================================================================
// Port-level checks of the execute core
module marx_checker (
  // Clock and reset
  input wire        aclk,
  input wire        aresetn,
  // Bus handshakes
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  // Execution state
  input wire        exec_busy,
  input wire [2:0]  aux_register_pointer
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Steps of a write and of an execution
  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence busy_start;
    $rose(exec_busy);
  endsequence
  // Pointer moves only during an execution or as a write lands
  ptr_cause_a: assert property ($changed(aux_register_pointer) |-> s_axi_bvalid || $past(exec_busy))
    else $error("pointer moved without cause");
  // Execution starts right after an accepted write
  busy_cause_a: assert property (busy_start |-> $past(s_axi_bvalid))
    else $error("busy without a write");
  // Longest run is 255 repeats plus 15 waits
  busy_bound_a: assert property (busy_start |-> ##[1:271] !exec_busy)
    else $error("busy too long");
  // Bus answers
  wr_answer_a: assert property (both_taken |-> ##[1:2] s_axi_bvalid)
    else $error("no write response");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("no read response");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  w_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  r_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
endmodule // marx_checker

bind marx_core marx_checker marx_checker_i (.*);

// ### bench/testbench.sv
`timescale 1ns/100ps
`include "marx_defs.vh"
// ==========================================================================
// Self-checking bench of the execute core
module testbench;
  logic        aclk = 0;
  logic        aresetn = 0;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
  logic [2:0]  s_axi_awprot = 0, s_axi_arprot = 0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, exec_busy;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire  [2:0]  aux_register_pointer;
  int          num_errors = 0, checks = 0, cyc = 0, c;
  // Mode results for AR 0110h and index 0010h
  logic [15:0] mres [8] = '{16'h0110, 16'h010F, 16'h0111, 16'h0110, 16'h0100, 16'h0100, 16'h0120, 16'h0108};
  // Control words and expected busy lengths
  logic [31:0] cw [4] = '{32'h0000_0301, 32'h0000_0023, 32'h0000_0323, 32'h0000_0021};
  int          cn [4] = '{3, 3, 5, 1};

  marx_core marx_core_i (.*);

  // ========================================================================
  // Clock and hang guard, sized well above the longest run
  initial forever #25 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      conclude;
    end
  end

  // ========================================================================
  // Shared tasks
  task chk(input [31:0] s, input [31:0] e, input string m);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %0t %s seen %h exp %h", $time, m, s, e);
    end
  endtask
  task do_reset;
    @(posedge aclk);
    aresetn <= 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1;
  endtask
  // Address and data offered together, each dropped when taken
  task wr(input [31:0] a, input [31:0] d, output [1:0] r);
    bit ad, wd;
    ad = 0;
    wd = 0;
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_wdata <= d;
    s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (s_axi_awready && !ad) begin ad = 1; s_axi_awvalid <= 0; end
      if (s_axi_wready && !wd) begin wd = 1; s_axi_wvalid <= 0; end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task rd(input [31:0] a, output [31:0] d, output [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task wreg(input [31:0] a, input [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk(r, `MARX_RESP_OKAY, "bresp");
  endtask
  task rchk(input [31:0] a, input [31:0] e, input string m);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e, m);
  endtask
  // Start one instruction, count busy cycles; window covers any run
  task run(input [15:0] op);
    logic [1:0] r;
    wr(`MARX_OFS_INSTR, {16'h0000, op}, r);
    c = 0;
    repeat (300) begin
      @(posedge aclk);
      if (exec_busy === 1'b1) c++;
    end
  endtask

  // ========================================================================
  // Scenarios
  task t_bus;
    logic [31:0] d;
    logic [1:0] r;
    rchk(`MARX_OFS_CTRL, 32'h0000_0001, "ctrl rst");
    rchk(`MARX_OFS_STATUS, 32'h0000_0000, "stat rst");
    rd(32'h0000_003C, d, r);
    chk(d, 32'h0000_0000, "unmapped rd");
    chk(r, `MARX_RESP_SLVERR, "unmapped rsp");
    wr(32'h0000_0100, 32'h0000_0001, r);
    chk(r, `MARX_RESP_SLVERR, "unmapped wr");
    $display("done bus");
  endtask
  task t_pointer;
    run(16'h8B89);
    chk(c, 1, "cycles");
    chk(aux_register_pointer, 3'h1, "ptr");
    rchk(`MARX_OFS_STATUS, 32'h0000_0010, "buf");
    rchk(`MARX_OFS_PC, 32'h0000_0001, "pc");
    wreg(`MARX_OFS_AR_BASE + 4, 32'h0000_0034);
    run(16'h8BAD);
    rchk(`MARX_OFS_AR_BASE + 4, 32'h0000_0035, "ar1");
    rchk(`MARX_OFS_STATUS, 32'h0000_0150, "ptr buf");
    $display("done pointer");
  endtask
  task t_direct;
    wreg(`MARX_OFS_AR_BASE + 20, 32'h0000_0077);
    run(16'h8B05);
    chk(c, 1, "cycles");
    rchk(`MARX_OFS_AR_BASE + 20, 32'h0000_0077, "ar5");
    rchk(`MARX_OFS_STATUS, 32'h0000_0150, "no change");
    rchk(`MARX_OFS_PC, 32'h0000_0003, "pc");
    $display("done direct");
  endtask
  task t_modes;
    wreg(`MARX_OFS_LDST, 32'h0000_0002);
    chk(aux_register_pointer, 3'h2, "ldst ptr");
    rchk(`MARX_OFS_STATUS, 32'h0000_0120, "ldst buf");
    for (int m = 0; m < 8; m++) begin
      wreg(`MARX_OFS_AR_BASE + 8, 32'h0000_0110);
      wreg(`MARX_OFS_INDEX, 32'h0000_0010);
      run({8'h8B, 1'b1, m[2:0], 4'h0});
      rchk(`MARX_OFS_AR_BASE + 8, {16'h0000, mres[m]}, "mode");
    end
    $display("done modes");
  endtask
  task t_compat;
    wreg(`MARX_OFS_CTRL, 32'h0000_0000);
    wreg(`MARX_OFS_LDST, 32'h0000_0000);
    wreg(`MARX_OFS_AR_BASE, 32'h0000_0040);
    run(16'h8BA0);
    rchk(`MARX_OFS_CMP, 32'h0000_0041, "cmp mirror");
    rchk(`MARX_OFS_INDEX, 32'h0000_0041, "idx mirror");
    wreg(`MARX_OFS_CTRL, 32'h0000_0001);
    run(16'h8BA0);
    rchk(`MARX_OFS_CMP, 32'h0000_0041, "cmp kept");
    $display("done compat");
  endtask
  task t_cycles;
    for (int i = 0; i < 4; i++) begin
      wreg(`MARX_OFS_CTRL, cw[i]);
      run(16'h8BA0);
      chk(c, cn[i], "cycles");
    end
    rchk(`MARX_OFS_AR_BASE, 32'h0000_004A, "repeats");
    $display("done cycles");
  endtask
  task t_badop;
    run(16'h8A89);
    chk(c, 0, "bad busy");
    rchk(`MARX_OFS_STATUS, 32'h0000_0102, "bad flag");
    rchk(`MARX_OFS_PC, 32'h0000_0011, "pc");
    // Second word while a repeated pointer load runs is refused
    wreg(`MARX_OFS_CTRL, 32'h0000_0801);
    wreg(`MARX_OFS_INSTR, 32'h0000_8B89);
    wreg(`MARX_OFS_INSTR, 32'h0000_8B80);
    repeat (20) @(posedge aclk);
    rchk(`MARX_OFS_STATUS, 32'h0000_0114, "refused");
    rchk(`MARX_OFS_PC, 32'h0000_0012, "pc once");
    do_reset;
    chk(aux_register_pointer, 3'h0, "ptr rst");
    $display("done badop");
  endtask
  task conclude;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ========================================================================
  // Main sequence
  initial begin
    do_reset;
    t_bus;
    t_pointer;
    t_direct;
    t_modes;
    t_compat;
    t_cycles;
    t_badop;
    conclude;
  end
endmodule // testbench

// ### common/marx_defs.vh
// ==========================================================================
// ==========================================================================
`ifndef MARX_DEFS_VH
`define MARX_DEFS_VH

// ==========================================================================
// Register byte offsets
`define MARX_OFS_INSTR    8'h00
`define MARX_OFS_CTRL     8'h04
`define MARX_OFS_STATUS   8'h08
`define MARX_OFS_LDST     8'h0C
`define MARX_OFS_AR_BASE  8'h10
`define MARX_OFS_AR_LAST  8'h2C
`define MARX_OFS_CMP      8'h30
`define MARX_OFS_INDEX    8'h34
`define MARX_OFS_PC       8'h38

// ==========================================================================
// Instruction fields
`define MARX_OPCODE       8'h8B
`define MARX_OP_HI        15
`define MARX_OP_LO        8
`define MARX_IND_BIT      7
`define MARX_MODE_HI      6
`define MARX_MODE_LO      4
`define MARX_NEWPTR_BIT   3
`define MARX_NAR_HI       2
`define MARX_NAR_LO       0

// Indirect update modes
`define MARX_MODE_NONE    3'h0
`define MARX_MODE_DEC     3'h1
`define MARX_MODE_INC     3'h2
`define MARX_MODE_RSVD    3'h3
`define MARX_MODE_BRDEC   3'h4
`define MARX_MODE_IDXDEC  3'h5
`define MARX_MODE_IDXINC  3'h6
`define MARX_MODE_BRINC   3'h7

// ==========================================================================
// Control and status fields
`define MARX_CTRL_COMPAT  0
`define MARX_CTRL_EXT     1
`define MARX_CTRL_WS_HI   7
`define MARX_CTRL_WS_LO   4
`define MARX_CTRL_RPT_HI  15
`define MARX_CTRL_RPT_LO  8
`define MARX_ST_BUSY      0
`define MARX_ST_BADOP     1
`define MARX_ST_REFUSED   2
`define MARX_ST_PTR_LO    4
`define MARX_ST_BUF_LO    8

// ==========================================================================
// Reset values
`define MARX_RST_WORD     16'h0000
`define MARX_RST_PTR      3'h0
`define MARX_RST_COMPAT   1'b1
`define MARX_RST_WS       4'h0
`define MARX_RST_RPT      8'h00

// ==========================================================================
// Bus answers
`define MARX_RESP_OKAY    2'b00
`define MARX_RESP_SLVERR  2'b10

`endif

// ### logic/marx_ar_update.v
`timescale 1ns/100ps
// ==========================================================================
// Auxiliary register arithmetic for one indirect specifier
module marx_ar_update (
  // Operands
  input  wire [15:0] ar_cur,
  input  wire [15:0] index_val,
  input  wire [2:0]  mode,
  // Result
  output reg  [15:0] ar_new,
  output reg         ar_mod
);
`include "marx_defs.vh"

  // Bit reversal, used on both sides of the reverse-carry adder
  function [15:0] bitrev16;
    input [15:0] v;
    integer i;
    begin
      for (i = 0; i < 16; i = i + 1) begin
        bitrev16[i] = v[15 - i];
      end
    end
  endfunction

  // ==========================================================================
  // Update selection; reserved mode leaves the register alone
  always @* begin
    ar_new = ar_cur;
    ar_mod = 1'b1;
    case (mode)
      `MARX_MODE_DEC:    ar_new = ar_cur - 16'h0001;
      `MARX_MODE_INC:    ar_new = ar_cur + 16'h0001;
      `MARX_MODE_IDXDEC: ar_new = ar_cur - index_val;
      `MARX_MODE_IDXINC: ar_new = ar_cur + index_val;
      `MARX_MODE_BRINC:  ar_new = bitrev16(bitrev16(ar_cur) + bitrev16(index_val));
      `MARX_MODE_BRDEC:  ar_new = bitrev16(bitrev16(ar_cur) - bitrev16(index_val));
      default:           ar_mod = 1'b0;
    endcase
  end

endmodule // marx_ar_update

// ### logic/marx_core.v
`timescale 1ns/100ps
// ==========================================================================
// Modify-auxiliary-register execute unit behind an AXI4-Lite slave
module marx_core (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // Write address channel
  input  wire [31:0] s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // Write data channel
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // Write response channel
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  // Read address channel
  input  wire [31:0] s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // Read data channel
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  // Execution state
  output wire        exec_busy,
  output wire [2:0]  aux_register_pointer
);
`include "marx_defs.vh"

  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_WAIT = 2'd1;
  localparam [1:0] ST_EXEC = 2'd2;

  // ==========================================================================
  // Storage
  reg  [15:0] ar_r [0:7];
  reg  [15:0] aux_compare_register_r;
  reg  [15:0] index_register_r;
  reg  [15:0] pc_r;
  reg  [2:0]  ptr_r;
  reg  [2:0]  aux_pointer_buffer_r;
  reg  [15:0] instr_r;
  reg         index_compat_bit_r;
  reg         ext_fetch_r;
  reg  [3:0]  wait_states_r;
  reg  [7:0]  repeat_cnt_r;
  reg         bad_op_r;
  reg         refused_r;
  reg  [1:0]  state_r;
  reg  [3:0]  ws_left_r;
  reg  [7:0]  rep_left_r;
  reg         go_r;
  reg         exec_busy_r;
  // Bus side
  reg         awready_r;
  reg         wready_r;
  reg         aw_full_r;
  reg         w_full_r;
  reg  [31:0] awaddr_r;
  reg  [31:0] wdata_r;
  reg  [3:0]  wstrb_r;
  reg         bvalid_r;
  reg  [1:0]  bresp_r;
  reg         arready_r;
  reg         rvalid_r;
  reg  [31:0] rdata_r;
  reg  [1:0]  rresp_r;
  integer     k;

  // ==========================================================================
  // Byte-lane merge, shared by the auxiliary, instruction, compare and index registers
  function [15:0] lane_merge;
    input [15:0] old_v;
    input [15:0] new_v;
    input [1:0]  strb;
    integer b;
    begin
      for (b = 0; b < 2; b = b + 1) begin
        lane_merge[b*8 +: 8] = strb[b] ? new_v[b*8 +: 8] : old_v[b*8 +: 8];
      end
    end
  endfunction

  // Word index of an auxiliary register from its byte offset
  function [2:0] ar_idx;
    input [7:0] ofs;
    reg   [7:0] rel;
    begin
      rel    = ofs - `MARX_OFS_AR_BASE;
      ar_idx = rel[4:2];
    end
  endfunction

  // Register decode used for both read and write paths
  function mapped;
    input [31:0] addr;
    begin
      mapped = (addr[31:8] == 24'h00_0000) && (addr[1:0] == 2'b00) &&
               (addr[7:0] <= `MARX_OFS_PC);
    end
  endfunction

  // ==========================================================================
  // Instruction fields
  wire        op_match   = (instr_r[`MARX_OP_HI:`MARX_OP_LO] == `MARX_OPCODE);
  wire        indirect   = instr_r[`MARX_IND_BIT];
  wire [2:0]  ind_mode   = instr_r[`MARX_MODE_HI:`MARX_MODE_LO];
  wire        new_ptr    = instr_r[`MARX_NEWPTR_BIT];
  wire [2:0]  nar        = instr_r[`MARX_NAR_HI:`MARX_NAR_LO];
  wire [15:0] ar_cur     = ar_r[ptr_r];
  wire [15:0] ar_new;
  wire        ar_mod;
  wire        wr_go      = aw_full_r && w_full_r && !bvalid_r;
  wire [7:0]  wofs       = awaddr_r[7:0];
  wire [7:0]  rep_n      = (repeat_cnt_r == 8'h00) ? 8'h01 : repeat_cnt_r;
  wire        use_ws     = ext_fetch_r && (wait_states_r != 4'h0);

  // Arithmetic on the current register
  marx_ar_update u_upd (
    .ar_cur    (ar_cur),
    .index_val (index_register_r),
    .mode      (ind_mode),
    .ar_new    (ar_new),
    .ar_mod    (ar_mod)
  );

  // ==========================================================================
  // Write address and data capture, either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      awaddr_r  <= 32'h0000_0000;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `MARX_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awready_r) begin
        awaddr_r  <= s_axi_awaddr;
        aw_full_r <= 1'b1;
        awready_r <= 1'b0;
      end
      if (s_axi_wvalid && wready_r) begin
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
        w_full_r <= 1'b1;
        wready_r <= 1'b0;
      end
      // Readies stay low until the response is taken: one write at a time
      if (wr_go) begin
        bvalid_r  <= 1'b1;
        bresp_r   <= mapped(awaddr_r) ? `MARX_RESP_OKAY : `MARX_RESP_SLVERR;
        aw_full_r <= 1'b0;
        w_full_r  <= 1'b0;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Read channel; answer one cycle after the address is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= `MARX_RESP_OKAY;
    end else if (s_axi_arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rresp_r   <= mapped(s_axi_araddr) ? `MARX_RESP_OKAY : `MARX_RESP_SLVERR;
      rdata_r   <= 32'h0000_0000;
      if (mapped(s_axi_araddr)) begin
        if (s_axi_araddr[7:0] >= `MARX_OFS_AR_BASE && s_axi_araddr[7:0] <= `MARX_OFS_AR_LAST) begin
          rdata_r <= {16'h0000, ar_r[ar_idx(s_axi_araddr[7:0])]};
        end else begin
          case (s_axi_araddr[7:0])
            `MARX_OFS_INSTR:  rdata_r <= {16'h0000, instr_r};
            `MARX_OFS_CTRL:   rdata_r <= {16'h0000, repeat_cnt_r, wait_states_r, 2'b00,
                                          ext_fetch_r, index_compat_bit_r};
            `MARX_OFS_STATUS: rdata_r <= {21'h00_0000, aux_pointer_buffer_r, 1'b0, ptr_r,
                                          1'b0, refused_r, bad_op_r, go_r || (state_r != ST_IDLE)};
            `MARX_OFS_LDST:   rdata_r <= {29'h000_0000, ptr_r};
            `MARX_OFS_CMP:    rdata_r <= {16'h0000, aux_compare_register_r};
            `MARX_OFS_INDEX:  rdata_r <= {16'h0000, index_register_r};
            `MARX_OFS_PC:     rdata_r <= {16'h0000, pc_r};
            default:          rdata_r <= 32'h0000_0000;
          endcase
        end
      end
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // ==========================================================================
  // Architectural state: bus writes first, execution overrides in same cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      for (k = 0; k < 8; k = k + 1) begin
        ar_r[k] <= `MARX_RST_WORD;
      end
      aux_compare_register_r <= `MARX_RST_WORD;
      index_register_r       <= `MARX_RST_WORD;
      pc_r                   <= `MARX_RST_WORD;
      ptr_r                  <= `MARX_RST_PTR;
      aux_pointer_buffer_r   <= `MARX_RST_PTR;
      instr_r                <= `MARX_RST_WORD;
      index_compat_bit_r     <= `MARX_RST_COMPAT;
      ext_fetch_r            <= 1'b0;
      wait_states_r          <= `MARX_RST_WS;
      repeat_cnt_r           <= `MARX_RST_RPT;
      bad_op_r               <= 1'b0;
      refused_r              <= 1'b0;
      go_r                   <= 1'b0;
      state_r                <= ST_IDLE;
      ws_left_r              <= 4'h0;
      rep_left_r             <= 8'h00;
      exec_busy_r            <= 1'b0;
    end else begin
      if (wr_go && mapped(awaddr_r)) begin
        if (wofs >= `MARX_OFS_AR_BASE && wofs <= `MARX_OFS_AR_LAST) begin
          ar_r[ar_idx(wofs)] <= lane_merge(ar_r[ar_idx(wofs)], wdata_r[15:0], wstrb_r[1:0]);
        end
        case (wofs)
          `MARX_OFS_INSTR: begin
            // A new word while one is running is dropped and flagged
            if (go_r || state_r != ST_IDLE) begin
              refused_r <= 1'b1;
            end else begin
              instr_r   <= lane_merge(instr_r, wdata_r[15:0], wstrb_r[1:0]);
              go_r      <= 1'b1;
              refused_r <= 1'b0;
            end
          end
          `MARX_OFS_CTRL: begin
            if (wstrb_r[0]) begin
              index_compat_bit_r <= wdata_r[`MARX_CTRL_COMPAT];
              ext_fetch_r        <= wdata_r[`MARX_CTRL_EXT];
              wait_states_r      <= wdata_r[`MARX_CTRL_WS_HI:`MARX_CTRL_WS_LO];
            end
            if (wstrb_r[1]) begin
              repeat_cnt_r <= wdata_r[`MARX_CTRL_RPT_HI:`MARX_CTRL_RPT_LO];
            end
          end
          `MARX_OFS_LDST: begin
            if (wstrb_r[0]) begin
              ptr_r <= wdata_r[2:0];
            end
          end
          `MARX_OFS_CMP:   aux_compare_register_r <= lane_merge(aux_compare_register_r,
                                                                wdata_r[15:0], wstrb_r[1:0]);
          `MARX_OFS_INDEX: index_register_r <= lane_merge(index_register_r,
                                                          wdata_r[15:0], wstrb_r[1:0]);
          default: ;
        endcase
      end
      // Instruction sequencer
      case (state_r)
        ST_IDLE: begin
          if (go_r) begin
            go_r <= 1'b0;
            if (op_match) begin
              bad_op_r   <= 1'b0;
              pc_r       <= pc_r + 16'h0001;
              ws_left_r  <= wait_states_r;
              rep_left_r <= rep_n;
              // Wait states are paid once, even under repeat
              state_r    <= use_ws ? ST_WAIT : ST_EXEC;
              exec_busy_r <= 1'b1;
            end else begin
              bad_op_r <= 1'b1;
            end
          end
        end
        ST_WAIT: begin
          ws_left_r <= ws_left_r - 4'h1;
          if (ws_left_r == 4'h1) begin
            state_r <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          // Direct form changes nothing; memory is never touched
          if (indirect) begin
            if (ar_mod) begin
              ar_r[ptr_r] <= ar_new;
              if (ptr_r == 3'h0 && !index_compat_bit_r) begin
                aux_compare_register_r <= ar_new;
                index_register_r       <= ar_new;
              end
            end
            if (new_ptr) begin
              aux_pointer_buffer_r <= ptr_r;
              ptr_r                <= nar;
            end
          end
          rep_left_r <= rep_left_r - 8'h01;
          if (rep_left_r == 8'h01) begin
            state_r     <= ST_IDLE;
            exec_busy_r <= 1'b0;
          end
        end
        default: begin
          state_r     <= ST_IDLE;
          exec_busy_r <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================================
  // Outputs, all from flops
  assign s_axi_awready        = awready_r;
  assign s_axi_wready         = wready_r;
  assign s_axi_bvalid         = bvalid_r;
  assign s_axi_bresp          = bresp_r;
  assign s_axi_arready        = arready_r;
  assign s_axi_rvalid         = rvalid_r;
  assign s_axi_rdata          = rdata_r;
  assign s_axi_rresp          = rresp_r;
  assign exec_busy            = exec_busy_r;
  assign aux_register_pointer = ptr_r;

endmodule // marx_core
